// ===== src/ccac_pkg.sv
// Constants, types and register map for the channel assessment control block.
// Assumes a simple byte-wide register port driven by an SPI front end elsewhere.
// Overview of operation
// RULE_01: Status bit 7 shows assessment finished
// RULE_02: Status bit 6 shows idle result
// RULE_03: New request clears done and result flags
// RULE_04: Offset 0x08 holds request, mode, channel
// RULE_05: Writing request bit one starts measurement
// RULE_06: Request bit always reads back zero
// RULE_07: Request bit clears itself after acceptance
// RULE_08: Request outside receive completes without measuring
// RULE_09: Every finished request pulses completion event
// RULE_10: Mode decode: OR, energy, carrier, AND
// RULE_11: Threshold register 0x09, resets 0xC7
// RULE_12: Busy when power above base plus twice threshold
// RULE_13: Link quality from multi-symbol correlation per frame
// RULE_14: Valid link quality needs two payload octets
// RULE_15: Link quality is unsigned byte 0..255
// RULE_16: Link quality byte appended to each frame
// RULE_17: Host reads link quality after frame end
// RULE_18: Listening result within 180 us of request
package ccac_pkg;
  localparam logic [7:0] ccac_addr_status    = 8'h01;
  localparam logic [7:0] ccac_addr_control   = 8'h08;
  localparam logic [7:0] ccac_addr_threshold = 8'h09;

  localparam int ccac_bit_done    = 7;
  localparam int ccac_bit_idle    = 6;
  localparam int ccac_bit_request = 7;

  localparam logic [1:0] ccac_mode_or     = 2'h0;
  localparam logic [1:0] ccac_mode_energy = 2'h1;
  localparam logic [1:0] ccac_mode_carrier= 2'h2;
  localparam logic [1:0] ccac_mode_and    = 2'h3;

  localparam logic [1:0] ccac_rst_mode      = 2'h1;
  localparam logic [4:0] ccac_rst_channel   = 5'h0b;
  localparam logic [3:0] ccac_rst_thr_upper = 4'hc;
  localparam logic [3:0] ccac_rst_thr       = 4'h7;

  localparam int ccac_clk_mhz     = 25;
  localparam int ccac_meas_us     = 128;
  localparam int ccac_max_us      = 180;
  localparam int ccac_meas_cycles = ccac_meas_us * ccac_clk_mhz;
  localparam int ccac_max_cycles  = ccac_max_us * ccac_clk_mhz;
  localparam int ccac_min_octets  = 2;

  typedef enum logic [1:0] {
    ccac_st_idle,
    ccac_st_measure,
    ccac_st_finish
  } ccac_phase_type;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccac_reg_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] octet;
    logic       last;
  } ccac_rx_byte_type;
endpackage : ccac_pkg

// ===== src/ccac_ctrl.sv
// Channel assessment control, status flags and link quality append logic.
// Assumes register accesses and receive bytes arrive synchronous to clk_sys.
`timescale 1ns/1ps
module ccac_ctrl #(
  parameter int meas_cycles = ccac_pkg::ccac_meas_cycles
) (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire ccac_pkg::ccac_reg_req_type reg_req,
  output logic [7:0]                      reg_rdata,
  input  wire logic [4:0]                 radio_state,
  input  wire logic                       in_receive,
  input  wire logic                       carrier_sense,
  input  wire logic [7:0]                 rx_power,
  input  wire logic [7:0]                 power_base_level,
  input  wire logic [7:0]                 symbol_corr,
  input  wire logic                       symbol_corr_valid,
  input  wire ccac_pkg::ccac_rx_byte_type rx_in,
  output ccac_pkg::ccac_rx_byte_type      rx_out,
  output logic                            assessment_complete_event,
  output logic                            frame_end_event,
  output logic [4:0]                      channel
);
  typedef struct packed {
    ccac_pkg::ccac_phase_type phase;
    logic [12:0]              count;
    logic [12:0]              result_wait;
    logic                     assessment_done;
    logic                     channel_idle_flag;
    logic                     energy_busy;
    logic                     carrier_busy;
    logic [1:0]               assessment_mode_select;
    logic [4:0]               channel;
    logic [3:0]               thr_upper;
    logic [3:0]               energy_threshold;
    logic                     complete;
    logic [15:0]              corr_sum;
    logic [7:0]               corr_n;
    logic [7:0]               octets;
    ccac_pkg::ccac_rx_byte_type rx_out;
    logic                     lq_pending;
    logic                     frame_end;
  } ccac_state_type;

  ccac_state_type state;
  ccac_state_type next_state;
  logic           write_control;
  logic           request;
  logic [8:0]     power_limit;
  logic           energy_over;
  logic           idle_result;
  logic [7:0]     lq_value;

  assign write_control = reg_req.wr_en && reg_req.addr == ccac_pkg::ccac_addr_control;
  assign request = write_control && reg_req.wdata[ccac_pkg::ccac_bit_request]; // see RULE_05
  assign power_limit = {1'b0, power_base_level}
                     + {4'h0, state.energy_threshold, 1'b0}; // see RULE_12
  assign energy_over = {1'b0, rx_power} > power_limit; // see RULE_12
  assign lq_value = (state.corr_n == 8'h00) ? 8'h00 : state.corr_sum[15:8]; // see RULE_15

  always_comb begin
    case (state.assessment_mode_select) // see RULE_10
      ccac_pkg::ccac_mode_or:      idle_result = !(state.energy_busy || state.carrier_busy);
      ccac_pkg::ccac_mode_energy:  idle_result = !state.energy_busy;
      ccac_pkg::ccac_mode_carrier: idle_result = !state.carrier_busy;
      ccac_pkg::ccac_mode_and:     idle_result = !(state.energy_busy && state.carrier_busy);
      default:                     idle_result = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.complete = 1'b0;
    next_state.frame_end = 1'b0;
    next_state.rx_out.valid = 1'b0;
    next_state.rx_out.last = 1'b0;
    if (reg_req.wr_en && reg_req.addr == ccac_pkg::ccac_addr_threshold) begin // see RULE_11
      next_state.thr_upper = reg_req.wdata[7:4];
      next_state.energy_threshold = reg_req.wdata[3:0];
    end
    if (write_control) begin // see RULE_04
      next_state.assessment_mode_select = reg_req.wdata[6:5];
      next_state.channel = reg_req.wdata[4:0];
    end
    case (state.phase)
      ccac_pkg::ccac_st_idle: begin
        next_state.phase = ccac_pkg::ccac_st_idle;
      end
      ccac_pkg::ccac_st_measure: begin
        next_state.energy_busy = state.energy_busy || energy_over;
        next_state.carrier_busy = state.carrier_busy || carrier_sense;
        next_state.count = state.count + 13'h0001;
        if (state.count >= 13'(meas_cycles - 1)) begin // see RULE_18
          next_state.phase = ccac_pkg::ccac_st_finish;
        end
      end
      ccac_pkg::ccac_st_finish: begin
        next_state.assessment_done = 1'b1; // see RULE_01
        next_state.channel_idle_flag = idle_result; // see RULE_02
        next_state.complete = 1'b1; // see RULE_09
        next_state.phase = ccac_pkg::ccac_st_idle;
      end
      default: next_state.phase = ccac_pkg::ccac_st_idle;
    endcase
    if (state.phase == ccac_pkg::ccac_st_idle) begin // see RULE_18
      next_state.result_wait = 13'h0000;
    end else if (state.result_wait != 13'h1fff) begin
      next_state.result_wait = state.result_wait + 13'h0001;
    end
    if (request) begin // see RULE_07
      next_state.assessment_done = 1'b0; // see RULE_03
      next_state.channel_idle_flag = 1'b0; // see RULE_03
      next_state.energy_busy = 1'b0;
      next_state.carrier_busy = 1'b0;
      next_state.count = 13'h0000;
      next_state.result_wait = 13'h0000;
      if (in_receive) begin
        next_state.phase = ccac_pkg::ccac_st_measure;
        next_state.complete = 1'b0;
      end else begin
        next_state.phase = ccac_pkg::ccac_st_idle;
        next_state.assessment_done = 1'b1; // see RULE_08
        next_state.complete = 1'b1; // see RULE_08
      end
    end
    if (symbol_corr_valid && state.corr_n != 8'hff) begin // see RULE_13
      next_state.corr_sum = state.corr_sum - {8'h00, state.corr_sum[15:8]} + {8'h00, symbol_corr};
      next_state.corr_n = state.corr_n + 8'h01;
    end
    if (state.lq_pending) begin // see RULE_16
      next_state.lq_pending = 1'b0;
      next_state.rx_out.valid = 1'b1;
      next_state.rx_out.octet = 8'h00; // see RULE_14
      if (state.octets >= 8'(ccac_pkg::ccac_min_octets)) begin
        next_state.rx_out.octet = lq_value;
      end
      next_state.rx_out.last = 1'b1;
      next_state.frame_end = 1'b1;
      next_state.corr_sum = 16'h0000;
      next_state.corr_n = 8'h00;
      next_state.octets = 8'h00;
    end else if (rx_in.valid) begin
      next_state.rx_out.valid = 1'b1;
      next_state.rx_out.octet = rx_in.octet;
      next_state.octets = (state.octets == 8'hff) ? 8'hff : state.octets + 8'h01;
      next_state.lq_pending = rx_in.last;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= '0;
      state.phase <= ccac_pkg::ccac_st_idle;
      state.assessment_mode_select <= ccac_pkg::ccac_rst_mode;
      state.channel <= ccac_pkg::ccac_rst_channel;
      state.thr_upper <= ccac_pkg::ccac_rst_thr_upper;
      state.energy_threshold <= ccac_pkg::ccac_rst_thr;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    case (reg_req.addr)
      ccac_pkg::ccac_addr_status:
        reg_rdata = {state.assessment_done, state.channel_idle_flag, 1'b0, radio_state};
      ccac_pkg::ccac_addr_control:
        reg_rdata = {1'b0, state.assessment_mode_select, state.channel}; // see RULE_06
      ccac_pkg::ccac_addr_threshold:
        reg_rdata = {state.thr_upper, state.energy_threshold};
      default: reg_rdata = 8'h00;
    endcase
  end

  assign assessment_complete_event = state.complete;
  assign frame_end_event = state.frame_end; // see RULE_17
  assign rx_out = state.rx_out;
  assign channel = state.channel;

  property p_request_clears;
    @(posedge clk_sys) disable iff (sys_rst)
      request && in_receive |=> !state.assessment_done && !state.channel_idle_flag;
  endproperty
  a_request_clears: assert property (p_request_clears) // see RULE_03
    else $error("flags not cleared");

  property p_no_meas_done;
    @(posedge clk_sys) disable iff (sys_rst)
      request && !in_receive |=> assessment_complete_event && state.assessment_done;
  endproperty
  a_no_meas_done: assert property (p_no_meas_done) // see RULE_08
    else $error("no-measure done missing");

  property p_done_bit;
    @(posedge clk_sys) disable iff (sys_rst)
      reg_req.addr == ccac_pkg::ccac_addr_status |-> reg_rdata[7] == state.assessment_done;
  endproperty
  a_done_bit: assert property (p_done_bit) // see RULE_01
    else $error("done bit wrong");

  property p_idle_bit;
    @(posedge clk_sys) disable iff (sys_rst)
      reg_req.addr == ccac_pkg::ccac_addr_status |-> reg_rdata[6] == state.channel_idle_flag;
  endproperty
  a_idle_bit: assert property (p_idle_bit) // see RULE_02
    else $error("idle bit wrong");

  property p_request_reads_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      reg_req.addr == ccac_pkg::ccac_addr_control |-> !reg_rdata[7];
  endproperty
  a_request_reads_zero: assert property (p_request_reads_zero) // see RULE_06
    else $error("request reads 1");

  property p_event_sets_done;
    @(posedge clk_sys) disable iff (sys_rst)
      assessment_complete_event |-> state.assessment_done;
  endproperty
  a_event_sets_done: assert property (p_event_sets_done) // see RULE_09
    else $error("event without done");

  property p_event_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
      assessment_complete_event && !request |=> !assessment_complete_event;
  endproperty
  a_event_pulse: assert property (p_event_pulse) // see RULE_09
    else $error("event longer than one cycle");

  property p_flags_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      !request && state.phase != ccac_pkg::ccac_st_finish |=>
        $stable(state.assessment_done) && $stable(state.channel_idle_flag);
  endproperty
  a_flags_hold: assert property (p_flags_hold) // see RULE_03
    else $error("flags changed without request");

  sequence s_started;
    request && in_receive;
  endsequence
  sequence s_waiting;
    state.phase != ccac_pkg::ccac_st_idle;
  endsequence

  property p_measure_starts;
    @(posedge clk_sys) disable iff (sys_rst)
      s_started |=> s_waiting;
  endproperty
  a_measure_starts: assert property (p_measure_starts) // see RULE_05
    else $error("measure not started");

  property p_result_time;
    @(posedge clk_sys) disable iff (sys_rst)
      s_waiting |-> state.result_wait <= 13'(ccac_pkg::ccac_max_cycles);
  endproperty
  a_result_time: assert property (p_result_time) // see RULE_18
    else $error("result too late");

  property p_no_restart;
    @(posedge clk_sys) disable iff (sys_rst)
      state.phase == ccac_pkg::ccac_st_finish && !request |=> state.phase == ccac_pkg::ccac_st_idle;
  endproperty
  a_no_restart: assert property (p_no_restart) // see RULE_07
    else $error("measure restarted without request");

  property p_energy_sticky;
    @(posedge clk_sys) disable iff (sys_rst)
      state.phase == ccac_pkg::ccac_st_measure && energy_over && !request |=> state.energy_busy;
  endproperty
  a_energy_sticky: assert property (p_energy_sticky) // see RULE_12
    else $error("energy busy not kept");

  property p_idle_update;
    @(posedge clk_sys) disable iff (sys_rst)
      state.phase == ccac_pkg::ccac_st_finish && !request |=>
        state.assessment_done && state.channel_idle_flag == $past(idle_result);
  endproperty
  a_idle_update: assert property (p_idle_update) // see RULE_10
    else $error("result not stored");

  property p_mode_write;
    @(posedge clk_sys) disable iff (sys_rst)
      write_control |=> state.assessment_mode_select == $past(reg_req.wdata[6:5]);
  endproperty
  a_mode_write: assert property (p_mode_write) // see RULE_04
    else $error("mode not stored");

  property p_channel_write;
    @(posedge clk_sys) disable iff (sys_rst)
      write_control |=> channel == $past(reg_req.wdata[4:0]);
  endproperty
  a_channel_write: assert property (p_channel_write) // see RULE_04
    else $error("channel not stored");

  property p_thr_write;
    @(posedge clk_sys) disable iff (sys_rst)
      reg_req.wr_en && reg_req.addr == ccac_pkg::ccac_addr_threshold |=>
        {state.thr_upper, state.energy_threshold} == $past(reg_req.wdata);
  endproperty
  a_thr_write: assert property (p_thr_write) // see RULE_11
    else $error("threshold not stored");

  property p_rx_pass;
    @(posedge clk_sys) disable iff (sys_rst)
      rx_in.valid && !state.lq_pending |=> rx_out.valid && rx_out.octet == $past(rx_in.octet);
  endproperty
  a_rx_pass: assert property (p_rx_pass) // see RULE_16
    else $error("frame byte not passed");

  property p_lq_short;
    @(posedge clk_sys) disable iff (sys_rst)
      state.lq_pending && state.octets < 8'(ccac_pkg::ccac_min_octets) |=> rx_out.octet == 8'h00;
  endproperty
  a_lq_short: assert property (p_lq_short) // see RULE_14
    else $error("short frame quality not zero");

  property p_lq_restart;
    @(posedge clk_sys) disable iff (sys_rst)
      state.lq_pending |=> state.corr_n == 8'h00 && state.octets == 8'h00;
  endproperty
  a_lq_restart: assert property (p_lq_restart) // see RULE_13
    else $error("quality not restarted per frame");

  property p_lq_append;
    @(posedge clk_sys) disable iff (sys_rst)
      rx_in.valid && rx_in.last |=> ##1 rx_out.valid && rx_out.last && frame_end_event;
  endproperty
  a_lq_append: assert property (p_lq_append) // see RULE_16
    else $error("quality byte missing");
endmodule : ccac_ctrl

// ===== tb/ccac_host.sv
// Host model for ccac_ctrl: byte-wide register writes and reads.
// Assumes one clk_sys domain; requests change on falling edges only.
`timescale 1ns/1ps
module ccac_host (
  input  wire logic                  clk_sys,
  output ccac_pkg::ccac_reg_req_type reg_req,
  input  wire logic [7:0]            reg_rdata
);
  initial reg_req = '0;

  // One-cycle write strobe, taken at the rising edge between
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{wr_en: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys);
    reg_req.wr_en = 1'b0;
  endtask : wr

  // Read is combinational on the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_req.addr = a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : ccac_host

// ===== tb/ccac_ctrl_tb_top.sv
// Testbench for ccac_ctrl: registers, assessments and quality byte.
// Assumes the host model in ccac_host.sv and a short measure window.
`timescale 1ns/1ps
module ccac_ctrl_tb_top;
  localparam int meas = 8;
  logic                       clk_sys = 1'b0;
  logic                       sys_rst = 1'b1;
  logic [4:0]                 radio_state = 5'h16;
  logic                       in_receive = 1'b0;
  logic                       carrier_sense = 1'b0;
  logic [7:0]                 rx_power = 8'h00;
  logic [7:0]                 power_base_level = 8'h40;
  logic [7:0]                 symbol_corr = 8'h00;
  logic                       symbol_corr_valid = 1'b0;
  ccac_pkg::ccac_reg_req_type reg_req;
  ccac_pkg::ccac_rx_byte_type rx_in = '0;
  ccac_pkg::ccac_rx_byte_type rx_out;
  logic [7:0]                 reg_rdata;
  logic [7:0]                 rd_val;
  logic                       ev_done;
  logic                       ev_frame;
  logic [4:0]                 channel;
  int                         n_errors = 0;
  int                         compares = 0;
  int                         n;
  int                         n_out;
  logic [7:0]                 rst_addr [4] = '{8'h01, 8'h08, 8'h09, 8'h02};
  logic [7:0]                 rst_exp [4] = '{8'h16, 8'h2b, 8'hc7, 8'h00};

  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (rx_out.valid === 1'b1) begin
      if (rx_out.last !== 1'b1) check(rx_out.octet === 8'h30 + 8'(n_out), "frame byte");
      n_out <= n_out + 1;
    end
  end

  ccac_ctrl #(.meas_cycles(meas)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .radio_state(radio_state),
    .in_receive(in_receive), .carrier_sense(carrier_sense), .rx_power(rx_power),
    .power_base_level(power_base_level), .symbol_corr(symbol_corr),
    .symbol_corr_valid(symbol_corr_valid), .rx_in(rx_in), .rx_out(rx_out),
    .assessment_complete_event(ev_done), .frame_end_event(ev_frame),
    .channel(channel));
  ccac_host host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

  task automatic summarize;
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  // Count falling edges until the chosen event pulses
  task automatic wait_sig(input logic frame);
    n = 0;
    while ((frame ? ev_frame : ev_done) !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(n < 40, "event missing");
  endtask : wait_sig

  task automatic assess(input logic [1:0] m, input logic cs, input logic en);
    logic busy;
    busy = (m == 2'h0) ? (cs | en) : (m == 2'h1) ? en : (m == 2'h2) ? cs : (cs & en);
    carrier_sense = cs;
    rx_power = en ? 8'h47 : 8'h46;
    host.wr(8'h08, {1'b1, m, 5'h05});
    host.rd(8'h01, rd_val);
    check(rd_val[7:6] === 2'b00, "flags not cleared");
    wait_sig(1'b0);
    check(n >= meas && n <= meas + 2, "measure time");
    host.rd(8'h01, rd_val);
    check(rd_val[7:6] === {1'b1, !busy}, "result flags");
  endtask : assess

  task automatic frame(input int len, input logic [7:0] exp_q);
    n_out = 0;
    for (int k = 0; k < len; k++) begin
      @(negedge clk_sys);
      rx_in = '{valid: 1'b1, octet: 8'h30 + 8'(k), last: (k == len - 1)};
      symbol_corr = 8'hf0;
      symbol_corr_valid = 1'b1;
    end
    @(negedge clk_sys);
    rx_in = '0;
    symbol_corr_valid = 1'b0;
    wait_sig(1'b1);
    check(rx_out.valid === 1'b1 && rx_out.last === 1'b1, "appended byte");
    if (len < 2) check(rx_out.octet === exp_q, "short frame quality");
    @(negedge clk_sys);
    check(n_out == len + 1, "byte count");
  endtask : frame

  initial begin
    #50us;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.rd(rst_addr[i], rd_val);
      check(rd_val === rst_exp[i], "reset value");
    end
    host.wr(8'h09, 8'hc3);
    host.rd(8'h09, rd_val);
    check(rd_val === 8'hc3, "threshold write");
    host.wr(8'h08, 8'ha5);
    wait_sig(1'b0);
    check(n <= 2, "completion without measuring");
    host.rd(8'h01, rd_val);
    check(rd_val[7] === 1'b1 && rd_val[5:0] === 6'h16, "done flag");
    host.rd(8'h08, rd_val);
    check(rd_val === 8'h25 && channel === 5'h05, "request reads zero");
    in_receive = 1'b1;
    for (int i = 0; i < 16; i++) assess(2'(i), i[2], i[3]);
    frame(4, 8'h00);
    frame(1, 8'h00);
    summarize();
  end
endmodule : ccac_ctrl_tb_top
